//--- verilog/alglm_cfg.svh
`ifndef ALGLM_CFG_SVH
`define ALGLM_CFG_SVH

// Register offsets
`define ALG_ADDR_GLP 8'h2C
`define ALG_ADDR_RHT 8'h2D
`define ALG_ADDR_LEM 8'h2E
`define ALG_ADDR_PSC 8'h2F
`define ALG_ADDR_CLP 8'h69
`define ALG_REG_RST 16'h0000

// Field positions
`define ALG_ZC_BIT 14
`define ALG_PKTYPE_BIT 11
`define ALG_CEIL_HI 7
`define ALG_CEIL_LO 5
`define ALG_FLOOR_HI 3
`define ALG_FLOOR_LO 1
`define ALG_REL_HI 15
`define ALG_REL_LO 12
`define ALG_ATK_HI 11
`define ALG_ATK_LO 8
`define ALG_HOLD_HI 7
`define ALG_HOLD_LO 4
`define ALG_TGT_HI 3
`define ALG_TGT_LO 0
`define ALG_EN_BIT 15
`define ALG_MODE_HI 14
`define ALG_MODE_LO 12
`define ALG_GZC_BIT 14
`define ALG_PSRC_BIT 13
`define ALG_CSTEP_HI 12
`define ALG_CSTEP_LO 10
`define ALG_CLIPEN_BIT 4

// Mode codes and gain limits (gain in 0.1875 dB steps, 0 = 0 dB)
`define ALG_MODE_CLIP 3'h0
`define ALG_CLIP_FLOOR 10'sh356
`define ALG_HOLD_MAX_CODE 4'h9
`define ALG_PEAK_DECAY_SH 8

// Timing
`define ALG_CLK_NS 50
`define ALG_RATE_BASE_NS 2000
`define ALG_RATE_BASE_CYC ((`ALG_RATE_BASE_NS + `ALG_CLK_NS - 1) / `ALG_CLK_NS)
`define ALG_HOLD_UNIT_US 2000
`define ALG_HOLD_UNIT_CYC (`ALG_HOLD_UNIT_US * 1000 / `ALG_CLK_NS)

`endif

//--- verilog/alglm_pkg.sv
package alglm_pkg;
	typedef enum logic [1:0] {ALG_IDLE, ALG_ATTACK, ALG_HOLD, ALG_RELEASE} alglm_state_t;
	typedef logic signed [9:0] alglm_gain_t;
	typedef logic signed [15:0] alglm_smp_t;
endpackage : alglm_pkg

//--- verilog/alglm_peak_det.sv
`timescale 1ns/1ps
`include "alglm_cfg.svh"
module alglm_peak_det import alglm_pkg::*; (
	input wire logic clk_sys, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic smp_valid, // Sample strobe
	input wire alglm_smp_t smp, // Sample value
	input wire logic peak_type_sel, // 0 rectified, 1 captured with decay
	output logic [15:0] peak_level, // Detected peak magnitude
	output logic zero_cross // Pulse on a sign change or zero sample
);
	logic [15:0] mag;
	logic sign_r;

	// Magnitude of the sample; -full scale still fits unsigned
	assign mag = smp[15] ? 16'(-smp) : 16'(smp);

	// Peak follows the rectified sample, or holds and decays slowly
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			peak_level <= 16'h0000;
		end else if (smp_valid) begin
			if (!peak_type_sel || mag >= peak_level) begin
				peak_level <= mag;
			end else begin
				peak_level <= peak_level - (peak_level >> `ALG_PEAK_DECAY_SH);
			end
		end
	end

	// Zero crossing marks where a gain step makes no audible click
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sign_r <= 1'b0;
			zero_cross <= 1'b0;
		end else begin
			zero_cross <= smp_valid && (smp == 16'sh0000 || smp[15] != sign_r);
			if (smp_valid) begin
				sign_r <= smp[15];
			end
		end
	end
endmodule : alglm_peak_det

//--- verilog/alglm_top.sv
`timescale 1ns/1ps
`include "alglm_cfg.svh"
module alglm_top import alglm_pkg::*; #(
	parameter logic [23:0] HOLD_UNIT_CYC = 24'(`ALG_HOLD_UNIT_CYC),
	parameter logic [20:0] RATE_BASE_CYC = 21'(`ALG_RATE_BASE_CYC)
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic reg_wr, // Register write strobe
	input wire logic reg_rd, // Register read strobe
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [15:0] reg_wdata, // Register write data
	output logic [15:0] reg_rdata, // Register read data
	input wire logic dgs_valid, // Gain stage output sample strobe
	input wire alglm_smp_t dgs_smp, // Gain stage output sample
	input wire logic smc_valid, // Soft-mute compensated sample strobe
	input wire alglm_smp_t smc_smp, // Soft-mute compensated sample
	input wire logic clip_in, // Clip detector output, level
	output alglm_gain_t gain_out, // Gain to the gain stage
	output logic gain_load, // Pulse when gain_out changes
	output logic gain_stage_zc, // Zero-cross update to the gain stage
	output logic clip_det_enable, // Enable to the clip detector
	output alglm_state_t alc_state // Controller state
);
	// Control registers
	logic [15:0] glp_r;
	logic [15:0] rht_r;
	logic [15:0] lem_r;
	logic [15:0] psc_r;
	logic [15:0] clp_r;

	// Controller state
	alglm_state_t st_r;
	alglm_state_t st_nxt;
	alglm_gain_t gain_r;
	logic [20:0] rate_cnt_r;
	logic [23:0] hold_cnt_r;
	logic [3:0] sess_cnt_r;
	logic step_pend_r;

	// Decoded controls
	logic en;
	logic clip_mode;
	logic zc_need;
	alglm_gain_t ceil_g;
	alglm_gain_t floor_raw;
	alglm_gain_t floor_g;
	logic [3:0] cap;
	logic [20:0] rate_len;
	logic [23:0] hold_len;

	// Level detection
	logic pk_valid;
	alglm_smp_t pk_smp;
	logic [15:0] peak;
	logic zero_cross;
	logic [15:0] thr;
	logic [15:0] thr_low;
	logic above;
	logic quiet;
	logic trigger;
	logic calm;

	// Step control
	logic tick;
	logic step_go;
	logic at_floor;
	logic at_ceil;
	logic cap_hit;
	logic hold_done;

	// Gain code to 0.1875 dB steps: one code is 6 dB, i.e. 32 steps
	function automatic alglm_gain_t code_to_gain(input logic [2:0] c);
		code_to_gain = -$signed({2'b00, c, 5'h00});
	endfunction : code_to_gain

	// Step period doubles with each rate code
	function automatic logic [20:0] rate_cycles(input logic [3:0] c);
		rate_cycles = RATE_BASE_CYC << c;
	endfunction : rate_cycles

	// Hold time doubles per code; codes above the top one saturate
	function automatic logic [23:0] hold_cycles(input logic [3:0] c);
		logic [3:0] sh;
		sh = (c > `ALG_HOLD_MAX_CODE) ? (`ALG_HOLD_MAX_CODE - 4'h1) : (c - 4'h1);
		hold_cycles = (c == 4'h0) ? 24'h000000 : (HOLD_UNIT_CYC << sh);
	endfunction : hold_cycles

	// Register writes; no side effects beyond storing
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			glp_r <= `ALG_REG_RST;
			rht_r <= `ALG_REG_RST;
			lem_r <= `ALG_REG_RST;
			psc_r <= `ALG_REG_RST;
			clp_r <= `ALG_REG_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ALG_ADDR_GLP: glp_r <= reg_wdata;
				`ALG_ADDR_RHT: rht_r <= reg_wdata;
				`ALG_ADDR_LEM: lem_r <= reg_wdata;
				`ALG_ADDR_PSC: psc_r <= reg_wdata;
				`ALG_ADDR_CLP: clp_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Registered readback; unmapped addresses read zero
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ALG_ADDR_GLP: reg_rdata <= glp_r;
				`ALG_ADDR_RHT: reg_rdata <= rht_r;
				`ALG_ADDR_LEM: reg_rdata <= lem_r;
				`ALG_ADDR_PSC: reg_rdata <= psc_r;
				`ALG_ADDR_CLP: reg_rdata <= clp_r;
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	// Field decode
	assign en = lem_r[`ALG_EN_BIT];
	assign clip_mode = lem_r[`ALG_MODE_HI:`ALG_MODE_LO] == `ALG_MODE_CLIP;
	assign zc_need = glp_r[`ALG_ZC_BIT];
	assign ceil_g = code_to_gain(~glp_r[`ALG_CEIL_HI:`ALG_CEIL_LO]);
	assign floor_raw = code_to_gain(glp_r[`ALG_FLOOR_HI:`ALG_FLOOR_LO]);
	// Clip mode never lets the floor go below -32 dB
	assign floor_g = (clip_mode && floor_raw < `ALG_CLIP_FLOOR) ?
		`ALG_CLIP_FLOOR : floor_raw;
	// Cap in 0.25 dB codes, converted to whole 0.1875 dB steps
	assign cap = 4'(({2'b00, psc_r[`ALG_CSTEP_HI:`ALG_CSTEP_LO]} << 2) / 5'h03);
	assign hold_len = hold_cycles(rht_r[`ALG_HOLD_HI:`ALG_HOLD_LO]);

	// Step period of the current ramp direction
	always_comb begin
		if (st_r == ALG_RELEASE) begin
			rate_len = rate_cycles(rht_r[`ALG_REL_HI:`ALG_REL_LO]);
		end else begin
			rate_len = rate_cycles(rht_r[`ALG_ATK_HI:`ALG_ATK_LO]);
		end
	end

	// Peak detector input source
	assign pk_valid = psc_r[`ALG_PSRC_BIT] ? smc_valid : dgs_valid;
	assign pk_smp = psc_r[`ALG_PSRC_BIT] ? smc_smp : dgs_smp;

	alglm_peak_det u_peak (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.smp_valid(pk_valid),
		.smp(pk_smp),
		.peak_type_sel(glp_r[`ALG_PKTYPE_BIT]),
		.peak_level(peak),
		.zero_cross(zero_cross)
	);

	// Target as a linear fraction of full scale; low mark is about 1.5 dB under
	assign thr = {1'b0, rht_r[`ALG_TGT_HI:`ALG_TGT_LO], 11'h7FF};
	assign thr_low = thr - (thr >> 3) - (thr >> 5);
	assign above = peak > thr;
	assign quiet = peak < thr_low;

	// Clip mode reacts to the clip detector, other modes to amplitude
	assign trigger = clip_mode ? clip_in : above;
	assign calm = clip_mode ? (!clip_in && quiet) : quiet;

	// Step timing; a pending step may wait for a zero crossing
	assign tick = (st_r == ALG_ATTACK || st_r == ALG_RELEASE) &&
		(rate_cnt_r >= rate_len - 21'h000001);
	assign step_go = step_pend_r && (!zc_need || zero_cross);
	assign at_floor = gain_r <= floor_g;
	assign at_ceil = gain_r >= ceil_g;
	assign cap_hit = sess_cnt_r >= cap;
	assign hold_done = calm && hold_cnt_r >= hold_len;

	// Next state
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			ALG_IDLE: begin
				// After the ceiling load, wait in hold for a trigger
				if (en) begin
					st_nxt = ALG_HOLD;
				end
			end
			ALG_ATTACK: begin
				if (clip_mode) begin
					// Session ends when clipping stops, the cap or the floor is met
					if (!clip_in || cap_hit || at_floor) begin
						st_nxt = ALG_HOLD;
					end
				end else if (step_go && quiet) begin
					st_nxt = ALG_HOLD;
				end
			end
			ALG_HOLD: begin
				// A fresh clip or level excursion starts a new session
				if (trigger && !(clip_mode && at_floor)) begin
					st_nxt = ALG_ATTACK;
				end else if (hold_done) begin
					st_nxt = ALG_RELEASE;
				end
			end
			ALG_RELEASE: begin
				if (trigger) begin
					st_nxt = ALG_ATTACK;
				end
			end
		endcase
		if (!en) begin
			st_nxt = ALG_IDLE;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_r <= ALG_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Step period counter, restarted on every state change
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rate_cnt_r <= 21'h000000;
		end else if (st_nxt != st_r || tick) begin
			rate_cnt_r <= 21'h000000;
		end else if (st_r == ALG_ATTACK || st_r == ALG_RELEASE) begin
			rate_cnt_r <= rate_cnt_r + 21'h000001;
		end
	end

	// Pending step; dropped on a state change so no stale step leaks
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			step_pend_r <= 1'b0;
		end else if (st_nxt != st_r) begin
			step_pend_r <= 1'b0;
		end else if (tick) begin
			step_pend_r <= 1'b1;
		end else if (step_go) begin
			step_pend_r <= 1'b0;
		end
	end

	// Hold timer counts only while calm and restarts on any excursion
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hold_cnt_r <= 24'h000000;
		end else if (st_r != ALG_HOLD || !calm) begin
			hold_cnt_r <= 24'h000000;
		end else if (hold_cnt_r < hold_len) begin
			hold_cnt_r <= hold_cnt_r + 24'h000001;
		end
	end

	// Attenuation taken in the current attack session
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sess_cnt_r <= 4'h0;
		end else if (st_r != ALG_ATTACK) begin
			sess_cnt_r <= 4'h0;
		end else if (step_go && !at_floor && !cap_hit) begin
			sess_cnt_r <= sess_cnt_r + 4'h1;
		end
	end

	// Gain: ceiling load on enable, single steps down and up, clamped
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gain_r <= 10'sh000;
			gain_load <= 1'b0;
		end else begin
			gain_load <= 1'b0;
			if (st_r == ALG_IDLE && en) begin
				// No ramp here: the ceiling applies at once
				gain_r <= ceil_g;
				gain_load <= 1'b1;
			end else if (st_r == ALG_ATTACK && step_go && !at_floor) begin
				if (!clip_mode || !cap_hit) begin
					gain_r <= gain_r - 10'sh001;
					gain_load <= 1'b1;
				end
			end else if (st_r == ALG_RELEASE && step_go && !at_ceil && calm) begin
				// Rise only while the level sits well under the target
				gain_r <= gain_r + 10'sh001;
				gain_load <= 1'b1;
			end
		end
	end

	// Outputs
	assign gain_out = gain_r;
	assign alc_state = st_r;
	// Zero-cross update if either the level controller's or the gain stage's own choice selects it
	assign gain_stage_zc = zc_need | psc_r[`ALG_GZC_BIT];
	// Clip reports arrive only while software keeps this enabled
	assign clip_det_enable = clp_r[`ALG_CLIPEN_BIT];
endmodule : alglm_top

//--- testbench/alglm_checker.sv
`timescale 1ns/1ps
`include "alglm_cfg.svh"
module alglm_checker import alglm_pkg::*; #(
	parameter logic [23:0] HOLD_UNIT_CYC = 24'h009C40,
	parameter logic [20:0] RATE_BASE_CYC = 21'h000028
) (
	input wire logic clk_sys, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [7:0] reg_addr, // Address
	input wire logic [15:0] reg_wdata, // Write data
	input wire logic [15:0] reg_rdata, // Read data
	input wire logic dgs_valid, // Gain stage strobe
	input wire alglm_smp_t dgs_smp, // Gain stage sample
	input wire logic smc_valid, // Soft-mute strobe
	input wire alglm_smp_t smc_smp, // Soft-mute sample
	input wire logic clip_in, // Clip flag
	input wire alglm_gain_t gain_out, // Gain
	input wire logic gain_load, // Gain update pulse
	input wire logic gain_stage_zc, // Zero-cross select
	input wire logic clip_det_enable, // Clip detector enable
	input wire alglm_state_t alc_state // State
);
	logic [15:0] c2c_r, c2e_r, c2f_r, c69_r;
	alglm_gain_t ceil_g, floor_g;
	logic en_wr;
	assign en_wr = reg_wr && reg_addr == `ALG_ADDR_LEM;
	// Shadow registers: the limits are not visible at the ports otherwise
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			c2c_r <= 16'h0000;
			c2e_r <= 16'h0000;
			c2f_r <= 16'h0000;
			c69_r <= 16'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
				`ALG_ADDR_GLP: c2c_r <= reg_wdata;
				`ALG_ADDR_LEM: c2e_r <= reg_wdata;
				`ALG_ADDR_PSC: c2f_r <= reg_wdata;
				`ALG_ADDR_CLP: c69_r <= reg_wdata;
				default: ;
			endcase
		end
	end
	// Gain limits; clip mode has its own lower bound
	always_comb begin
		ceil_g = -$signed({2'h0, 3'h7 - c2c_r[7:5], 5'h00});
		floor_g = -$signed({2'h0, c2c_r[3:1], 5'h00});
		if (c2e_r[14:12] == `ALG_MODE_CLIP && floor_g < `ALG_CLIP_FLOOR)
			floor_g = `ALG_CLIP_FLOOR;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s_en_write;
		en_wr && reg_wdata[15] && alc_state == ALG_IDLE;
	endsequence
	sequence s_ceil_load;
		alc_state == ALG_IDLE ##1 alc_state == ALG_HOLD && gain_load && gain_out == ceil_g;
	endsequence
	a_enable_loads_ceiling: assert property (s_en_write |=> s_ceil_load)
		else $error("enable did not load ceiling");
	a_disable_goes_idle: assert property (en_wr && !reg_wdata[15] |=> ##1 alc_state == ALG_IDLE)
		else $error("disable did not idle");
	a_idle_gain_frozen: assert property (alc_state == ALG_IDLE && !c2e_r[15] && !en_wr |=> $stable(gain_out))
		else $error("gain moved while idle");
	a_clip_starts_attack: assert property (c2e_r[15] && c2e_r[14:12] == `ALG_MODE_CLIP && !reg_wr
		&& alc_state == ALG_HOLD && clip_in && gain_out > floor_g |=> alc_state == ALG_ATTACK)
		else $error("clip in hold did not attack");
	a_hold_before_release: assert property (alc_state == ALG_ATTACK |=> alc_state != ALG_RELEASE)
		else $error("release straight after attack");
	a_attack_no_rise: assert property ($past(alc_state) == ALG_ATTACK |-> gain_out <= $past(gain_out))
		else $error("gain rose in attack");
	a_release_no_fall: assert property ($past(alc_state) == ALG_RELEASE && alc_state != ALG_IDLE
		|-> gain_out >= $past(gain_out))
		else $error("gain fell in release");
	a_gain_in_bounds: assert property (alc_state inside {ALG_ATTACK, ALG_RELEASE}
		|-> gain_out <= ceil_g && gain_out >= floor_g)
		else $error("gain outside limits");
	a_zc_select_mirror: assert property (gain_stage_zc == (c2c_r[14] | c2f_r[14]))
		else $error("zero-cross select wrong");
	a_clip_det_mirror: assert property (clip_det_enable == c69_r[4])
		else $error("clip detector enable wrong");
	a_step_spacing_min: assert property (gain_load |=> !gain_load)
		else $error("gain steps too close");
endmodule : alglm_checker

bind alglm_top alglm_checker #(.HOLD_UNIT_CYC(HOLD_UNIT_CYC), .RATE_BASE_CYC(RATE_BASE_CYC)) u_chk (
	.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dgs_valid(dgs_valid), .dgs_smp(dgs_smp),
	.smc_valid(smc_valid), .smc_smp(smc_smp), .clip_in(clip_in), .gain_out(gain_out),
	.gain_load(gain_load), .gain_stage_zc(gain_stage_zc), .clip_det_enable(clip_det_enable),
	.alc_state(alc_state)
);

//--- testbench/test_auto_level_gain_limiter.sv
`timescale 1ns/1ps
`include "alglm_cfg.svh"
module test_auto_level_gain_limiter import alglm_pkg::*;;
	localparam logic [15:0] G_CEIL = 16'hFFE0; // Ceiling code 6
	localparam logic [15:0] G_CAP = 16'hFFDC; // Ceiling less one capped event
	localparam logic [15:0] G_FLR = 16'hFF56; // Clip-mode floor
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, clip_in = 1'b0;
	logic dgs_valid = 1'b0, smc_valid = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	alglm_smp_t dgs_smp = 16'sh0000, smc_smp = 16'sh0000;
	alglm_gain_t gain_out;
	logic gain_load, gain_stage_zc, clip_det_enable;
	alglm_state_t alc_state;
	int n_mismatch = 0;
	int checks = 0;
	// 20 MHz clock
	always #25 clk_sys = ~clk_sys;
	// Short units so hold and step periods fit a brief run
	alglm_top #(.HOLD_UNIT_CYC(24'h000004), .RATE_BASE_CYC(21'h000002)) dut (
		.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dgs_valid(dgs_valid), .dgs_smp(dgs_smp),
		.smc_valid(smc_valid), .smc_smp(smc_smp), .clip_in(clip_in), .gain_out(gain_out),
		.gain_load(gain_load), .gain_stage_zc(gain_stage_zc), .clip_det_enable(clip_det_enable),
		.alc_state(alc_state)
	);
	task automatic wrap_up;
		if (n_mismatch == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// Bounded wait on the gain (g=1) or the state; a timeout ends the run
	task automatic wt(input bit g, input logic [15:0] v, input int lim, output int cnt);
		cnt = 0;
		#1;
		while ((g ? 16'(gain_out) : 16'(alc_state)) !== v) begin
			@(posedge clk_sys);
			#1;
			cnt++;
			if (cnt > lim) begin
				n_mismatch++;
				wrap_up();
			end
		end
	endtask : wt
	task automatic s_regs;
		logic [15:0] d;
		logic [7:0] ad [5] = '{`ALG_ADDR_GLP, `ALG_ADDR_RHT, `ALG_ADDR_LEM, `ALG_ADDR_PSC,
			`ALG_ADDR_CLP};
		foreach (ad[i]) begin
			rd(ad[i], d);
			chk(d, `ALG_REG_RST);
		end
		wr(`ALG_ADDR_CLP, 16'h0010);
		rd(`ALG_ADDR_CLP, d);
		chk(d, 16'h0010);
		chk(16'(clip_det_enable), 16'h0001);
		wr(`ALG_ADDR_PSC, 16'h4C00);
		#1 chk(16'(gain_stage_zc), 16'h0001);
		wr(`ALG_ADDR_GLP, 16'h40CE);
		wr(`ALG_ADDR_PSC, 16'h0C00);
		#1 chk(16'(gain_stage_zc), 16'h0001);
		wr(`ALG_ADDR_GLP, 16'h00CE);
		#1 chk(16'(gain_stage_zc), 16'h0000);
		wr(8'h30, 16'hA5A5);
		rd(8'h30, d);
		chk(d, 16'h0000);
	endtask : s_regs
	task automatic s_enable;
		wr(`ALG_ADDR_RHT, 16'h0040);
		wr(`ALG_ADDR_LEM, 16'h8000);
		cyc(2);
		#1 chk(16'(gain_out), G_CEIL);
		chk(16'(alc_state), 16'(ALG_HOLD));
	endtask : s_enable
	task automatic s_clip;
		int n;
		@(posedge clk_sys);
		clip_in <= 1'b1;
		wt(0, 16'(ALG_ATTACK), 4, n);
		wt(0, 16'(ALG_HOLD), 40, n);
		clip_in <= 1'b0;
		cyc(2);
		#1 chk(16'(gain_out), G_CAP);
		wt(0, 16'(ALG_RELEASE), 60, n);
		chk(16'(n >= 30 && n <= 36), 16'h0001);
		wt(1, G_CEIL, 40, n);
		cyc(20);
		#1 chk(16'(gain_out), G_CEIL);
		chk(16'(alc_state), 16'(ALG_RELEASE));
	endtask : s_clip
	task automatic s_floor;
		int n;
		@(posedge clk_sys);
		clip_in <= 1'b1;
		wt(1, G_FLR, 900, n);
		cyc(20);
		#1 chk(16'(gain_out), G_FLR);
	endtask : s_floor
	// Clip during hold aborts it and the hold timer starts over
	task automatic s_hold_abort;
		int n;
		@(posedge clk_sys);
		clip_in <= 1'b0;
		wt(0, 16'(ALG_RELEASE), 60, n);
		// A few release steps lift the gain off the floor so a clip can attack
		cyc(6);
		clip_in <= 1'b1;
		cyc(1);
		clip_in <= 1'b0;
		wt(0, 16'(ALG_HOLD), 10, n);
		cyc(10);
		clip_in <= 1'b1;
		cyc(1);
		clip_in <= 1'b0;
		#1 chk(16'(alc_state), 16'(ALG_ATTACK));
		wt(0, 16'(ALG_RELEASE), 80, n);
		chk(16'(n >= 32 && n <= 40), 16'h0001);
	endtask : s_hold_abort
	task automatic s_disable;
		logic [15:0] g0;
		int n;
		wr(`ALG_ADDR_LEM, 16'h0000);
		cyc(1);
		#1 chk(16'(alc_state), 16'(ALG_IDLE));
		g0 = 16'(gain_out);
		@(posedge clk_sys);
		clip_in <= 1'b1;
		cyc(20);
		#1 chk(16'(gain_out), g0);
		wr(`ALG_ADDR_LEM, 16'hA000);
		cyc(2);
		#1 chk(16'(gain_out), G_CEIL);
		cyc(20);
		#1 chk(16'(alc_state), 16'(ALG_HOLD));
		// Loud gain stage samples push the amplitude mode into attack
		@(posedge clk_sys);
		dgs_smp <= 16'sh7000;
		dgs_valid <= 1'b1;
		wt(0, 16'(ALG_ATTACK), 6, n);
		// Silent soft-mute source selected: the peak falls and attack ends
		wr(`ALG_ADDR_PSC, 16'h2C00);
		smc_valid <= 1'b1;
		wt(0, 16'(ALG_HOLD), 12, n);
		chk(16'(alc_state), 16'(ALG_HOLD));
	endtask : s_disable
	// Main sequence: reset for 10 cycles, then the scenarios
	initial begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		s_regs();
		s_enable();
		s_clip();
		s_floor();
		s_hold_abort();
		s_disable();
		wrap_up();
	end
endmodule : test_auto_level_gain_limiter
